// ### rtl/pmr_pkg.sv
// Constants and types for the power monitor register bank and I2C slave.
// Assumes a 250 MHz system clock and an external converter handshake.
package pmr_pkg;

  // ==========================================================
  // Register pointer values
  localparam logic [2:0] OFS_SENSE_HI   = 3'h0;
  localparam logic [2:0] OFS_SENSE_LO   = 3'h1;
  localparam logic [2:0] OFS_SUPPLY_HI  = 3'h2;
  localparam logic [2:0] OFS_SUPPLY_LO  = 3'h3;
  localparam logic [2:0] OFS_AUX_HI     = 3'h4;
  localparam logic [2:0] OFS_AUX_LO     = 3'h5;
  localparam logic [2:0] OFS_CONTROL    = 3'h6;
  localparam logic [2:0] OFS_RESERVED   = 3'h7;
  localparam logic [2:0] PTR_RESET      = 3'h0;

  // ==========================================================
  // Control register fields
  localparam int SNAPSHOT_ENABLE_BIT        = 7;
  localparam int CHANNEL_SELECT_HIGH_BIT    = 6;
  localparam int CHANNEL_SELECT_LOW_BIT     = 5;
  localparam int TEST_MODE_BIT              = 4;
  localparam int PAGE_TRANSFER_ENABLE_BIT   = 3;
  localparam int STUCK_BUS_TIMER_ENABLE_BIT = 2;
  localparam logic [7:0] CONTROL_RESET      = 8'h0c;
  localparam int LOW_BUSY_BIT               = 3;

  // ==========================================================
  // Converter channels and result layout
  localparam int RESULT_WIDTH = 12;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
  localparam logic [1:0] CH_SENSE  = 2'h0;
  localparam logic [1:0] CH_SUPPLY = 2'h1;
  localparam logic [1:0] CH_AUX    = 2'h2;
  localparam logic [1:0] CH_NONE   = 2'h3;

  // ==========================================================
  // I2C addressing
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h67;
  localparam logic [6:0] MASS_WRITE_ADDR  = 7'h66;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // ==========================================================
  // Stuck-bus timing
  localparam int CLK_FREQ_KHZ     = 250000;
  localparam int STUCK_TIME_MS    = 33;
  localparam int STUCK_CYCLES     = STUCK_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } pmr_i2c_state_t;

endpackage

// ### rtl/pmr_sync.sv
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin idles at RESET_VAL.
`timescale 1ns/1ns
`default_nettype none
module pmr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic stable;
  } pmr_sync_t;

  pmr_sync_t s;
  pmr_sync_t next_s;

  always_comb begin
    next_s.meta = i_async;
    next_s.stable = s.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= {RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign o_sync = s.stable;

endmodule
`default_nettype wire

// ### rtl/pmr_stuck_timer.sv
// Stuck-bus timer: pulses once when a bus line stays low too long.
// Assumes synchronised line levels on the same clock.
`timescale 1ns/1ns
`default_nettype none
module pmr_stuck_timer #(
  parameter int CYCLES = pmr_pkg::STUCK_CYCLES,
  parameter int CW     = $clog2(CYCLES + 1)
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_expire
);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          fired;
    logic          expire;
  } pmr_timer_t;

  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  pmr_timer_t s;
  pmr_timer_t next_s;

  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    if (!i_enable || (i_scl && i_sda)) begin
      next_s.count = '0;
      next_s.fired = 1'b0;
    end else if (s.count >= LIMIT) begin
      next_s.expire = ~s.fired;
      next_s.fired = 1'b1;
    end else begin
      next_s.count = s.count + CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_expire = s.expire;

endmodule
`default_nettype wire

// ### rtl/pmr_regs_i2c.sv
// Power monitor register bank with I2C slave access and converter
// sequencing. Assumes an external converter that takes o_conv_req with
// o_conv_chan and answers with i_conv_done plus i_conv_code, same clock.
// SCL and SDA arrive from pins; SDA is open drain, low while o_sda_oe.
//
// Overview of operation
// R1: Supply result is 12 bits: high register, then low register bits 7:4.
// R2: Supply low bit 3 reads busy during snapshot conversion; unwritable.
// R3: Aux result is 12 bits: high register, then low register bits 7:4.
// R4: Aux low bit 3 reads busy during snapshot conversion; unwritable.
// R5: Result low bits 2:0 and control bits 1:0 read zero, ignore writes.
// R6: Snapshot mode converts selected channel once, clears busy, then halts.
// R7: Snapshot bit clear, the reset default, lets the converter free-run.
// R8: Control bits 6 and 5 pick the snapshot channel.
// R9: Select code 00 sense, 01 supply, 10 aux.
// R10: Test mode halts conversion and allows writes to result registers.
// R11: Page bit, default set, advances the pointer per byte; clear holds the pointer and ends writes after one data byte.
// R12: Stuck-bus bit, default set, runs the stuck-bus timer.
// R13: Repeated start with read address returns the pointed register.
// R14: Master acknowledge sends next register, advancing the pointer while page bit set.
// R15: Stop ends the transfer and returns the pointer to zero.
// R16: Command byte loads only its low three bits into the pointer.
// R17: Bus line low beyond 33 ms with timer enabled resets I2C logic.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_i2c #(
  parameter logic [6:0] SLAVE_ADDR   = pmr_pkg::SLAVE_ADDR_RESET,
  parameter int         STUCK_CYCLES = pmr_pkg::STUCK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_conv_req,
  output logic [1:0]       o_conv_chan,
  input  wire logic        i_conv_done,
  input  wire logic [11:0] i_conv_code
);

  localparam int RW = pmr_pkg::RESULT_WIDTH;

  typedef struct packed {
    pmr_pkg::pmr_i2c_state_t st;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic [2:0]              ptr;
    logic                    rw;
    logic                    acked;
    logic                    wrote;
    logic                    scl_q;
    logic                    sda_q;
    logic                    sda_oe;
    logic                    sda_out;
    logic [7:2]              ctrl;
    logic [2:0][RW-1:0]      res;
    logic [2:0]              busy;
    logic                    conv_active;
    logic [1:0]              conv_chan;
    logic                    snap_pend;
    logic                    conv_req;
    logic [1:0]              rr;
  } pmr_top_t;

  pmr_top_t s;
  pmr_top_t next_s;

  logic scl_s;
  logic sda_s;
  logic stuck_expire;

  // ==========================================================
  // Pin synchronisers and stuck-bus timer
  pmr_sync #(
    .RESET_VAL (1'b1)
  ) u_sync_scl (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_scl),
    .o_sync  (scl_s)
  );

  pmr_sync #(
    .RESET_VAL (1'b1)
  ) u_sync_sda (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_sda),
    .o_sync  (sda_s)
  );

  pmr_stuck_timer #(
    .CYCLES (STUCK_CYCLES)
  ) u_stuck (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_enable (s.ctrl[pmr_pkg::STUCK_BUS_TIMER_ENABLE_BIT]), // R12
    .i_scl    (scl_s),
    .i_sda    (sda_s),
    .o_expire (stuck_expire)
  );

  // ==========================================================
  // Bus events and control decode
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       snapshot;
  logic       test_mode;
  logic       page_en;
  logic [1:0] sel;
  logic [7:0] rd_byte;

  assign scl_rise  = scl_s & ~s.scl_q;
  assign scl_fall  = ~scl_s & s.scl_q;
  assign bus_start = s.scl_q & scl_s & s.sda_q & ~sda_s;
  assign bus_stop  = s.scl_q & scl_s & ~s.sda_q & sda_s;
  assign snapshot  = s.ctrl[pmr_pkg::SNAPSHOT_ENABLE_BIT];
  assign test_mode = s.ctrl[pmr_pkg::TEST_MODE_BIT];
  assign page_en   = s.ctrl[pmr_pkg::PAGE_TRANSFER_ENABLE_BIT];
  assign sel       = {s.ctrl[pmr_pkg::CHANNEL_SELECT_HIGH_BIT],
                      s.ctrl[pmr_pkg::CHANNEL_SELECT_LOW_BIT]}; // R8

  // ==========================================================
  // Register read view
  function automatic logic [7:0] read_reg(input pmr_top_t st_in,
                                          input logic     snap,
                                          input logic [2:0] ptr);
    logic [1:0] ch;
    logic       bsy;
    ch = ptr[2:1];
    bsy = 1'b0;
    read_reg = 8'h00;
    if (ptr == pmr_pkg::OFS_CONTROL) begin
      read_reg = {st_in.ctrl, 2'b00}; // R5
    end else if (ptr != pmr_pkg::OFS_RESERVED) begin
      bsy = snap & st_in.busy[ch]; // R2 R4
      if (!ptr[0]) begin
        read_reg = st_in.res[ch][RW-1:4]; // R1 R3
      end else begin
        read_reg = {st_in.res[ch][3:0], bsy, 3'b000}; // R1 R3 R5
      end
    end
  endfunction

  assign rd_byte = read_reg(s, snapshot, s.ptr);

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    next_s.sda_out = 1'b0;
    next_s.conv_req = 1'b0;

    // Converter sequencing
    if (s.conv_active && i_conv_done) begin
      next_s.conv_active = 1'b0;
      if (!test_mode) begin
        next_s.res[s.conv_chan] = i_conv_code;
        if (!s.snap_pend) begin
          next_s.busy[s.conv_chan] = 1'b0; // R6
        end
      end
    end else if (!s.conv_active && !test_mode) begin // R10
      if (snapshot) begin
        if (s.snap_pend) begin // R6
          next_s.snap_pend = 1'b0;
          if (sel != pmr_pkg::CH_NONE) begin // R9
            next_s.conv_req = 1'b1;
            next_s.conv_active = 1'b1;
            next_s.conv_chan = sel;
          end
        end
      end else begin // R7
        next_s.conv_req = 1'b1;
        next_s.conv_active = 1'b1;
        next_s.conv_chan = s.rr;
        if (s.rr == pmr_pkg::CH_AUX) begin
          next_s.rr = pmr_pkg::CH_SENSE;
        end else begin
          next_s.rr = s.rr + 2'h1;
        end
      end
    end

    // I2C slave
    if (scl_rise && s.cnt < pmr_pkg::BITS_PER_BYTE) begin
      next_s.cnt = s.cnt + 4'h1;
      if (s.st != pmr_pkg::ST_RDATA) begin
        next_s.sh = {s.sh[6:0], sda_s};
      end
    end

    unique case (s.st)
      pmr_pkg::ST_IDLE: begin
        next_s.sda_oe = 1'b0;
      end
      pmr_pkg::ST_ADDR: begin
        if (scl_fall && s.cnt == pmr_pkg::BITS_PER_BYTE) begin
          if (s.sh[7:1] == SLAVE_ADDR ||
              (s.sh[7:1] == pmr_pkg::MASS_WRITE_ADDR && !s.sh[0])) begin
            next_s.st = pmr_pkg::ST_ADDR_ACK;
            next_s.rw = s.sh[0];
            next_s.sda_oe = 1'b1;
          end else begin
            next_s.st = pmr_pkg::ST_IDLE;
          end
        end
      end
      pmr_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          next_s.wrote = 1'b0;
          if (s.rw) begin // R13
            next_s.st = pmr_pkg::ST_RDATA;
            next_s.sh = rd_byte;
            next_s.sda_oe = ~rd_byte[7];
          end else begin
            next_s.st = pmr_pkg::ST_CMD;
            next_s.sda_oe = 1'b0;
          end
        end
      end
      pmr_pkg::ST_CMD: begin
        if (scl_fall && s.cnt == pmr_pkg::BITS_PER_BYTE) begin
          next_s.ptr = s.sh[2:0]; // R16
          next_s.st = pmr_pkg::ST_CMD_ACK;
          next_s.sda_oe = 1'b1;
        end
      end
      pmr_pkg::ST_CMD_ACK: begin
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          next_s.st = pmr_pkg::ST_WDATA;
          next_s.sda_oe = 1'b0;
        end
      end
      pmr_pkg::ST_WDATA: begin
        if (scl_fall && s.cnt == pmr_pkg::BITS_PER_BYTE) begin
          if (s.wrote && !page_en) begin // R11
            next_s.st = pmr_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
          end else begin
            next_s.st = pmr_pkg::ST_WDATA_ACK;
            next_s.sda_oe = 1'b1;
            next_s.wrote = 1'b1;
            if (page_en) begin
              next_s.ptr = s.ptr + 3'h1; // R11
            end
            if (s.ptr == pmr_pkg::OFS_CONTROL) begin
              next_s.ctrl = s.sh[7:2]; // R5
              if (s.sh[pmr_pkg::SNAPSHOT_ENABLE_BIT]) begin
                next_s.snap_pend = 1'b1; // R6
                if (s.sh[6:5] != pmr_pkg::CH_NONE) begin
                  next_s.busy[s.sh[6:5]] = 1'b1; // R2 R4
                end
              end
            end else if (s.ptr != pmr_pkg::OFS_RESERVED && test_mode) begin
              if (!s.ptr[0]) begin
                next_s.res[s.ptr[2:1]][RW-1:4] = s.sh; // R10
              end else begin
                next_s.res[s.ptr[2:1]][3:0] = s.sh[7:4]; // R10 R5
              end
            end
          end
        end
      end
      pmr_pkg::ST_WDATA_ACK: begin
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          next_s.st = pmr_pkg::ST_WDATA;
          next_s.sda_oe = 1'b0;
        end
      end
      pmr_pkg::ST_RDATA: begin
        if (scl_fall) begin
          if (s.cnt == pmr_pkg::BITS_PER_BYTE) begin
            next_s.st = pmr_pkg::ST_RDATA_ACK;
            next_s.sda_oe = 1'b0;
            next_s.acked = 1'b0;
          end else begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.sda_oe = ~s.sh[6];
          end
        end
      end
      pmr_pkg::ST_RDATA_ACK: begin
        if (scl_rise) begin
          next_s.acked = ~sda_s;
          if (!sda_s && page_en) begin
            next_s.ptr = s.ptr + 3'h1; // R14 R11
          end
        end else if (scl_fall) begin
          if (s.acked) begin // R14
            next_s.st = pmr_pkg::ST_RDATA;
            next_s.cnt = 4'h0;
            next_s.sh = rd_byte;
            next_s.sda_oe = ~rd_byte[7];
          end else begin
            next_s.st = pmr_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
          end
        end
      end
    endcase

    // Bus conditions override the byte engine
    if (stuck_expire) begin
      next_s.st = pmr_pkg::ST_IDLE; // R17
      next_s.sda_oe = 1'b0;
      next_s.cnt = 4'h0;
    end else if (bus_stop) begin
      next_s.st = pmr_pkg::ST_IDLE; // R15
      next_s.ptr = pmr_pkg::PTR_RESET; // R15
      next_s.sda_oe = 1'b0;
    end else if (bus_start) begin
      next_s.st = pmr_pkg::ST_ADDR; // R13
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.st <= pmr_pkg::ST_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.ptr <= pmr_pkg::PTR_RESET;
      s.ctrl <= pmr_pkg::CONTROL_RESET[7:2]; // R7 R11 R12
      s.res <= {3{pmr_pkg::RESULT_RESET}};
      s.rr <= pmr_pkg::CH_SENSE;
    end else begin
      s <= next_s;
    end
  end

  assign o_sda_out   = s.sda_out;
  assign o_sda_oe    = s.sda_oe;
  assign o_conv_req  = s.conv_req;
  assign o_conv_chan = s.conv_chan;

endmodule
`default_nettype wire

// ### verification/pmr_regs_i2c_properties.sv
// Checker for the I2C slave pins and converter handshake.
// Assumes it is bound to pmr_regs_i2c and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_i2c_properties #(
  parameter logic [6:0] SLAVE_ADDR   = 7'h67,
  parameter int         STUCK_CYCLES = 200
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda_out,
  input wire logic        o_sda_oe,
  input wire logic        o_conv_req,
  input wire logic [1:0]  o_conv_chan,
  input wire logic        i_conv_done,
  input wire logic [11:0] i_conv_code
);
  // ==========================================================
  // Outstanding conversion tracker
  logic pend;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend <= 1'b0;
    end else if (o_conv_req) begin
      pend <= 1'b1;
    end else if (i_conv_done) begin
      pend <= 1'b0;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_oe_held;
    o_sda_oe [*8];
  endsequence
  sequence s_scl_low;
    !i_scl && !$past(i_scl, 2);
  endsequence
  chk_sda_zero: assert property (o_sda_out == 1'b0)
    else $error("sda output value not zero");
  chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> s_scl_low)
    else $error("sda drive changed while clock high");
  chk_oe_held: assert property ($rose(o_sda_oe) |-> s_oe_held)
    else $error("sda drive released too early");
  chk_req_pulse: assert property (o_conv_req |=> !o_conv_req)
    else $error("conversion request longer than one cycle");
  chk_chan_legal: assert property (o_conv_req |-> o_conv_chan != 2'h3)
    else $error("conversion on unused channel");
  chk_chan_hold: assert property (!o_conv_req |-> $stable(o_conv_chan))
    else $error("channel changed without request");
  chk_one_outst: assert property (o_conv_req |-> !pend || i_conv_done)
    else $error("second request while one outstanding");
  chk_free_start: assert property ($fell(i_rst) |->
    !o_sda_oe && !o_conv_req ##[1:3] o_conv_req)
    else $error("no free running request after reset");
endmodule
bind pmr_regs_i2c pmr_regs_i2c_properties #(
  .SLAVE_ADDR(SLAVE_ADDR), .STUCK_CYCLES(STUCK_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_conv_req(o_conv_req),
  .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done),
  .i_conv_code(i_conv_code));
`default_nettype wire

// ### verification/pmr_i2c_master.sv
// Behavioural I2C bus master driving SCL and pulling SDA low.
// Assumes SDA has a pull-up; SCL stands high outside frames.
`timescale 1ns/1ns
`default_nettype none
module pmr_i2c_master (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // One bit: data set while SCL low, sampled mid high
  task automatic bit_io(input logic b, output logic q);
    o_sda_oe = !b;
    #31 o_scl = 1'b1;
    #31 q = i_sda;
    #32 o_scl = 1'b0;
    #31;
  endtask
  // Start or repeated start
  task automatic start();
    o_sda_oe = 1'b0;
    #31 o_scl = 1'b1;
    #31 o_sda_oe = 1'b1;
    #31 o_scl = 1'b0;
    #32;
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    #31 o_scl = 1'b1;
    #31 o_sda_oe = 1'b0;
    #63;
  endtask
  // Ninth bit ab: 0 acknowledges a read byte
  task automatic xfer(input logic [7:0] w, input logic ab,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], q[i]);
    end
    bit_io(ab, ack);
  endtask
endmodule
`default_nettype wire

// ### verification/pmr_regs_i2c_tb.sv
// Testbench for the register bank with I2C slave access.
// Assumes pmr_i2c_master drives the bus; converter modelled here.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_i2c_tb;
  localparam logic [6:0] ADDR = pmr_pkg::SLAVE_ADDR_RESET;
  logic        i_clk, i_rst, done, conv_en, tm, pend, a;
  logic [11:0] code;
  logic [11:0] exp_code [3];
  logic [7:0]  rb [4];
  logic [7:0]  wb [4];
  logic [7:0]  r;
  logic [1:0]  ch;
  wire logic   scl, m_oe, d_oe, d_out, req;
  wire logic [1:0] chan;
  wire logic   sda = !(m_oe || d_oe);
  int          error_cnt, cmp_count, cyc, nreq, dly, n0;

  pmr_regs_i2c #(.STUCK_CYCLES(2000)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(d_out), .o_sda_oe(d_oe), .o_conv_req(req),
    .o_conv_chan(chan), .i_conv_done(done), .i_conv_code(code));
  pmr_i2c_master u_mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ==========================================================
  // Converter: answers after a random delay while enabled
  always @(negedge i_clk) begin
    done = pend && conv_en && dly == 0 && !req;
    if (done) begin
      code = 12'($urandom);
      pend = 1'b0;
      if (!tm) exp_code[ch] = code;
    end else if (pend && conv_en) begin
      dly--;
    end
    if (req) begin
      pend = 1'b1;
      ch = chan;
      dly = $urandom_range(9, 2);
      nreq++;
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] lo_b(logic [11:0] c, logic busy);
    return {c[3:0], busy, 3'h0};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, input logic cm);
    if (cm) begin
      u_mst.start();
      u_mst.xfer({ADDR, 1'b0}, 1'b1, r, a);
      u_mst.xfer(cmd, 1'b1, r, a);
    end
    u_mst.start();
    u_mst.xfer({ADDR, 1'b1}, 1'b1, r, a);
    chk({7'h0, a}, 8'h00);
    for (int k = 0; k < n; k++) begin
      u_mst.xfer(8'hff, k == n - 1, rb[k], a);
    end
    u_mst.stop();
  endtask
  task automatic wr(input logic [7:0] cmd, input int n);
    u_mst.start();
    u_mst.xfer({ADDR, 1'b0}, 1'b1, r, a);
    u_mst.xfer(cmd, 1'b1, r, a);
    for (int k = 0; k < n; k++) begin
      u_mst.xfer(wb[k], 1'b1, r, a);
    end
    u_mst.stop();
  endtask
  task automatic set_ctl(input logic [7:0] v);
    wb[0] = v;
    wr(8'h06, 1);
    tm = v[4];
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    done = 1'b0;
    code = 12'h000;
    conv_en = 1'b0;
    tm = 1'b0;
    pend = 1'b0;
    exp_code = '{default: 12'h000};
    void'($urandom(32'hbfe4c011));
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    rd(8'h06, 1, 1'b1);
    chk(rb[0], 8'h0c);
    rd(8'h02, 4, 1'b1);
    for (int k = 0; k < 4; k++) chk(rb[k], 8'h00);
    $display("reset values done");
    set_ctl(8'h1c);
    for (int k = 0; k < 4; k++) wb[k] = 8'($urandom);
    wr(8'h02, 4);
    rd(8'h02, 4, 1'b1);
    for (int k = 0; k < 4; k++) chk(rb[k], wb[k] & (k[0] ? 8'hf0 : 8'hff));
    set_ctl(8'h0c);
    wb[0] = ~rb[0];
    wr(8'h02, 1);
    rd(8'h02, 1, 1'b1);
    chk(rb[0], ~wb[0]);
    $display("test mode done");
    for (int s = 0; s < 3; s++) begin
      conv_en = 1'b0;
      set_ctl(8'h8c | 8'(s << 5));
      rd(8'(2 * s + 1), 1, 1'b1);
      chk(rb[0] & 8'h08, 8'h08);
      conv_en = 1'b1;
      repeat (100) @(negedge i_clk);
      n0 = nreq;
      repeat (200) @(negedge i_clk);
      chk(8'(nreq - n0), 8'h00);
      rd(8'(2 * s), 2, 1'b1);
      chk(rb[0], exp_code[s][11:4]);
      chk(rb[1], lo_b(exp_code[s], 1'b0));
    end
    set_ctl(8'hec);
    n0 = nreq;
    repeat (200) @(negedge i_clk);
    chk(8'(nreq - n0), 8'h00);
    $display("snapshot done");
    conv_en = 1'b0;
    set_ctl(8'h0c);
    rd(8'hf6, 3, 1'b1);
    chk(rb[0], 8'h0c);
    chk(rb[1], 8'h00);
    chk(rb[2], exp_code[0][11:4]);
    rd(8'h00, 1, 1'b0);
    chk(rb[0], exp_code[0][11:4]);
    set_ctl(8'h04);
    rd(8'h06, 2, 1'b1);
    chk(rb[0], 8'h04);
    chk(rb[1], 8'h04);
    $display("pointer done");
    u_mst.start();
    u_mst.xfer({7'h55, 1'b0}, 1'b1, r, a);
    u_mst.stop();
    chk({7'h0, a}, 8'h01);
    for (int m = 0; m < 2; m++) begin
      u_mst.start();
      u_mst.xfer({pmr_pkg::MASS_WRITE_ADDR, m[0]}, 1'b1, r, a);
      u_mst.stop();
      chk({7'h0, a}, 8'(m));
    end
    for (int t = 0; t < 2; t++) begin
      u_mst.start();
      u_mst.xfer({ADDR, 1'b0}, 1'b1, r, a);
      #10000;
      u_mst.xfer(8'h06, 1'b1, r, a);
      u_mst.stop();
      chk({7'h0, a}, 8'(1 - t));
      set_ctl(8'h00);
    end
    $display("bus faults done");
    stop_test();
  end
endmodule
`default_nettype wire
